// >>> src/hbc_breakpoint.sv
// Purpose: hardware breakpoint compare unit with an Avalon-MM register slave
// Assumes: cpu bus inputs are synchronous to clk_in and stable for one cycle per bus cycle
// Notes:   program-only breaks are tagged at fetch; the cpu reports tagged execution back
//
// Function
// R1: two mode bits select off, swi dual, full, dbg dual
// R2: no breakpoint while background debug mode active
// R3: only swi dual mode raises software interrupts
// R4: swi dual mode ignores direction compare bits
// R5: data enable bit enables second address breakpoint
// R6: size select ignored in dual modes
// R7: debug entry only when debug controller permits
// R8: dbg dual qualifies by program-only, range, direction
// R9: address regs vs address; data regs by mode
// R10: program-only breaks only on executed matched opcodes
// R11: swi dual mode always uses program breakpoints
// R12: second range bit selects 8 or 16 bits
// R13: first range bit clear drops low address byte
// R14: data enable clear removes data registers entirely
// R15: full mode high mask drops data bits 15:8
// R16: full mode low mask drops data bits 7:0
// R17: control 1 resets zero, top bit reads zero
// R18: software selects debug modes only when enabled; here ctrl0 mode bits are written regardless of bdm_enable_in
// R19: direction value one matches reads, zero writes
// R20: match gives one-cycle debug or swi request
module hbc_breakpoint
    import hbc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic [15:0] cpu_addr_in,
    input  wire logic [15:0] cpu_data_in,
    input  wire logic        cpu_read_in,
    input  wire logic        cpu_valid_in,
    input  wire logic        cpu_fetch_in,
    input  wire logic        cpu_boundary_in,
    input  wire logic        cpu_tag_exec_in,
    input  wire logic        bdm_active_in,
    input  wire logic        bdm_enable_in,
    output logic             tag_out,
    output logic             dbg_req_out,
    output logic             swi_req_out
);

    // whole module state in one record
    typedef struct packed
    {
        logic [7:0]  ctrl0;
        logic [7:0]  ctrl1;
        logic [7:0]  addr_hi;
        logic [7:0]  addr_lo;
        logic [7:0]  data_hi;
        logic [7:0]  data_lo;
        logic [1:0]  hit;
        logic        pend;
        logic        wait_n;
        logic [31:0] rdata;
        logic        tag;
        logic        dbg_req;
        logic        swi_req;
    } hbc_state_t;

    hbc_state_t st_q;
    hbc_state_t st_d;

    // decoded control fields
    hbc_mode_t  mode;
    logic       dual_mode;
    logic       prog_eff;
    logic       dir_used;
    logic       data_en;
    logic       hi_masked;
    logic       lo_masked;
    logic       hi_eq0;
    logic       lo_eq0;
    logic       dhi_eq;
    logic       dlo_eq;
    logic       dir_ok0;
    logic       dir_ok1;
    logic       data_ok;
    logic       bp0_match;
    logic       bp1_match;
    logic       any_match;
    logic       bus_req;
    logic       bus_take;
    logic [5:0] reg_idx;
    logic [31:0] rd_val;

    // field decode
    always_comb
    begin
        mode      = hbc_mode_t'({st_q.ctrl0[HBC_C0_MODE_HI], st_q.ctrl0[HBC_C0_MODE_LO]}); // R1
        dual_mode = (mode == HBC_MODE_SWI_DUAL) || (mode == HBC_MODE_DBG_DUAL);
        // swi dual always tags program fetches
        prog_eff  = (mode == HBC_MODE_SWI_DUAL) || st_q.ctrl0[HBC_C0_PROG_ONLY]; // R11
        // direction compare is meaningless in swi dual mode
        dir_used  = (mode != HBC_MODE_SWI_DUAL); // R4
        data_en   = st_q.ctrl1[HBC_C1_DATA_EN]; // R14
        // size select narrows the data compare only in full mode
        hi_masked = st_q.ctrl1[HBC_C1_HI_MASK]
                    || (!dual_mode && st_q.ctrl0[HBC_C0_SIZE_SEL]); // R6 R15
        lo_masked = st_q.ctrl1[HBC_C1_LO_MASK]; // R16
    end

    // comparators against the cpu buses
    always_comb
    begin
        hi_eq0  = (cpu_addr_in[15:8] == st_q.addr_hi); // R9
        lo_eq0  = !st_q.ctrl0[HBC_C0_RANGE1] || (cpu_addr_in[7:0] == st_q.addr_lo); // R13
        // data registers hold a second address in dual modes
        dhi_eq  = dual_mode ? (cpu_addr_in[15:8] == st_q.data_hi)
                            : (hi_masked || (cpu_data_in[15:8] == st_q.data_hi)); // R9 R15
        dlo_eq  = dual_mode ? (!st_q.ctrl0[HBC_C0_RANGE2] || (cpu_addr_in[7:0] == st_q.data_lo))
                            : (lo_masked || (cpu_data_in[7:0] == st_q.data_lo)); // R12 R16
        dir_ok0 = !dir_used || !st_q.ctrl1[HBC_C1_DIR1_EN]
                  || (cpu_read_in == st_q.ctrl1[HBC_C1_DIR1_VAL]); // R19 R8
        dir_ok1 = !dir_used || !st_q.ctrl1[HBC_C1_DIR2_EN]
                  || (cpu_read_in == st_q.ctrl1[HBC_C1_DIR2_VAL]); // R19 R8
        // in full mode the data compare joins the single breakpoint
        data_ok = dual_mode || !data_en || (dhi_eq && dlo_eq); // R14
    end

    // breakpoint match qualification
    always_comb
    begin
        bp0_match = (mode != HBC_MODE_OFF) && cpu_valid_in && !bdm_active_in
                    && hi_eq0 && lo_eq0 && dir_ok0 && data_ok; // R2 R8
        bp1_match = dual_mode && data_en && cpu_valid_in && !bdm_active_in
                    && dhi_eq && dlo_eq && dir_ok1; // R5 R2
        // with program-only set only opcode fetches may match
        any_match = (bp0_match || bp1_match) && (!prog_eff || cpu_fetch_in); // R10
    end

    // register read mux
    always_comb
    begin
        reg_idx = avs_address_in[7:2];
        rd_val  = HBC_RD_ZERO;
        unique case (reg_idx)
            HBC_IDX_CTRL0:   rd_val[7:0] = st_q.ctrl0;
            HBC_IDX_CTRL1:   rd_val[7:0] = st_q.ctrl1 & HBC_C1_WMASK; // R17
            HBC_IDX_ADDR_HI: rd_val[7:0] = st_q.addr_hi;
            HBC_IDX_ADDR_LO: rd_val[7:0] = st_q.addr_lo;
            HBC_IDX_DATA_HI: rd_val[7:0] = st_q.data_hi;
            HBC_IDX_DATA_LO: rd_val[7:0] = st_q.data_lo;
            HBC_IDX_STATUS:
            begin
                rd_val[HBC_ST_HIT1] = st_q.hit[0];
                rd_val[HBC_ST_HIT2] = st_q.hit[1];
                rd_val[HBC_ST_PEND] = st_q.pend;
            end
            default:         rd_val = HBC_RD_ZERO;
        endcase
    end

    // next-state logic: bus slave, match tracking and cpu requests
    always_comb
    begin
        st_d     = st_q;
        bus_req  = avs_read_in || avs_write_in;
        // a held request completes on the edge where wait is low
        bus_take = bus_req && !st_q.wait_n;
        st_d.wait_n = !(bus_req && st_q.wait_n);
        if (bus_req && st_q.wait_n)
        begin
            st_d.rdata = avs_read_in ? rd_val : HBC_RD_ZERO;
        end

        // register writes, low byte lane only
        if (bus_take && avs_write_in && avs_byteenable_in[0])
        begin
            unique case (reg_idx)
                HBC_IDX_CTRL0:   st_d.ctrl0   = avs_writedata_in[7:0];
                HBC_IDX_CTRL1:   st_d.ctrl1   = avs_writedata_in[7:0] & HBC_C1_WMASK; // R17
                HBC_IDX_ADDR_HI: st_d.addr_hi = avs_writedata_in[7:0];
                HBC_IDX_ADDR_LO: st_d.addr_lo = avs_writedata_in[7:0];
                HBC_IDX_DATA_HI: st_d.data_hi = avs_writedata_in[7:0];
                HBC_IDX_DATA_LO: st_d.data_lo = avs_writedata_in[7:0];
                HBC_IDX_STATUS:
                begin
                    // write one to clear the hit flags
                    if (avs_writedata_in[HBC_ST_HIT1])
                    begin
                        st_d.hit[0] = 1'b0;
                    end
                    if (avs_writedata_in[HBC_ST_HIT2])
                    begin
                        st_d.hit[1] = 1'b0;
                    end
                end
                default:         st_d.ctrl0 = st_q.ctrl0;
            endcase
        end

        // hit flags set after the clear so a same-cycle hit survives
        if (any_match && bp0_match)
        begin
            st_d.hit[0] = 1'b1;
        end
        if (any_match && bp1_match)
        begin
            st_d.hit[1] = 1'b1;
        end

        // request outputs default to idle each cycle
        st_d.tag     = 1'b0;
        st_d.dbg_req = 1'b0;
        st_d.swi_req = 1'b0;

        // program breaks mark the fetched opcode; data breaks wait for a boundary
        if (any_match && prog_eff)
        begin
            st_d.tag = 1'b1; // R10
        end

        // pending boundary break issued at the next instruction boundary
        if (st_q.pend && cpu_boundary_in)
        begin
            st_d.pend    = 1'b0;
            st_d.dbg_req = bdm_enable_in && !bdm_active_in && (mode != HBC_MODE_OFF); // R7 R20
        end
        if (any_match && !prog_eff)
        begin
            st_d.pend = 1'b1; // R10
        end

        // tagged opcode reached execution
        if (cpu_tag_exec_in && !bdm_active_in && (mode != HBC_MODE_OFF))
        begin
            st_d.swi_req = (mode == HBC_MODE_SWI_DUAL); // R3 R20
            st_d.dbg_req = (mode != HBC_MODE_SWI_DUAL) && bdm_enable_in; // R7 R20
        end

        // entering debug or turning breakpoints off drops any waiting break
        if (bdm_active_in || (mode == HBC_MODE_OFF))
        begin
            st_d.pend    = 1'b0; // R2
            st_d.tag     = 1'b0; // R2
            st_d.dbg_req = 1'b0; // R2
            st_d.swi_req = 1'b0; // R2
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            st_q.ctrl0   <= HBC_RST_BYTE;
            st_q.ctrl1   <= HBC_RST_BYTE; // R17
            st_q.addr_hi <= HBC_RST_BYTE;
            st_q.addr_lo <= HBC_RST_BYTE;
            st_q.data_hi <= HBC_RST_BYTE;
            st_q.data_lo <= HBC_RST_BYTE;
            st_q.hit     <= 2'h0;
            st_q.pend    <= 1'b0;
            st_q.wait_n  <= 1'b1;
            st_q.rdata   <= HBC_RD_ZERO;
            st_q.tag     <= 1'b0;
            st_q.dbg_req <= 1'b0;
            st_q.swi_req <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state flops
    assign avs_readdata_out    = st_q.rdata;
    assign avs_waitrequest_out = st_q.wait_n;
    assign tag_out             = st_q.tag;
    assign dbg_req_out         = st_q.dbg_req;
    assign swi_req_out         = st_q.swi_req;

    // checks on the behaviour above
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_bus_ack;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence

    sequence s_bus_wait;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence

    chk_off_no_req: assert property ((mode == HBC_MODE_OFF) |=> !dbg_req_out && !swi_req_out && !tag_out) // R1
        else $error("request raised while breakpoints off");

    chk_bdm_suppress: assert property (bdm_active_in |=> !dbg_req_out && !swi_req_out && !tag_out) // R2
        else $error("breakpoint raised while debug mode active");

    chk_swi_mode_only: assert property (swi_req_out |-> $past(mode) == HBC_MODE_SWI_DUAL) // R3
        else $error("software interrupt outside swi dual mode");

    chk_dbg_enable: assert property (dbg_req_out |-> $past(bdm_enable_in)) // R7
        else $error("debug request without debug enable");

    chk_ctrl1_top: assert property ((!avs_waitrequest_out && $past(avs_read_in) // R17
                                     && ($past(avs_address_in[7:2]) == HBC_IDX_CTRL1))
                                    |-> (avs_readdata_out[7] == 1'b0))
        else $error("control 1 top bit not read as zero");

    chk_single_req: assert property (!(dbg_req_out && swi_req_out)) // R20
        else $error("debug and swi requested together");

    chk_tag_fetch: assert property (tag_out |-> $past(cpu_fetch_in) && $past(cpu_valid_in)) // R10
        else $error("tag on a non-fetch cycle");

    chk_tag_addr: assert property (tag_out |-> $past(cpu_addr_in[15:8]) == $past(st_q.addr_hi) // R9
                                   || ($past(dual_mode) && $past(data_en)
                                       && $past(cpu_addr_in[15:8]) == $past(st_q.data_hi)))
        else $error("tag without address match");

    chk_data_pend: assert property (($past(mode) == HBC_MODE_DBG_FULL) && $rose(st_q.pend) // R15
                                    |-> (!$past(data_en) || $past(hi_masked)
                                         || ($past(cpu_data_in[15:8]) == $past(st_q.data_hi))))
        else $error("full break pended on high data mismatch");

    chk_bus_answer: assert property (s_bus_wait |=> s_bus_ack)
        else $error("bus request not answered in one cycle");

    // bus slave idle checks
    chk_wait_idle: assert property (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
        else $error("waitrequest low without a request");

    chk_rdata_hold: assert property (!(avs_read_in || avs_write_in) |=> $stable(avs_readdata_out))
        else $error("read data changed without a request");

    // compare path checks
    chk_low_range: assert property (st_q.ctrl0[HBC_C0_RANGE1] && (cpu_addr_in[7:0] != st_q.addr_lo) // R13
                                    |-> !bp0_match)
        else $error("first breakpoint ignored its low address byte");

    chk_second_off: assert property (!data_en |-> !bp1_match) // R5 R14
        else $error("second breakpoint matched with data compare off");

    chk_swi_dir: assert property ((mode == HBC_MODE_SWI_DUAL) |-> dir_ok0 && dir_ok1) // R4
        else $error("direction compare used in swi dual mode");

    chk_size_dual: assert property (dual_mode |-> (hi_masked == st_q.ctrl1[HBC_C1_HI_MASK])) // R6
        else $error("size select narrowed a dual mode compare");

    chk_hit_set: assert property (any_match && bp0_match |=> st_q.hit[0]) // R9
        else $error("first breakpoint hit flag not set");

    chk_hit2_set: assert property (any_match && bp1_match |=> st_q.hit[1]) // R5
        else $error("second breakpoint hit flag not set");

    // request path checks
    sequence s_pend_boundary;
        st_q.pend && cpu_boundary_in && bdm_enable_in && !bdm_active_in
        && ((mode == HBC_MODE_DBG_FULL) || (mode == HBC_MODE_DBG_DUAL));
    endsequence

    chk_pend_fire: assert property (s_pend_boundary |=> dbg_req_out) // R10 R20
        else $error("pending break not issued at boundary");

    chk_pend_prog: assert property ($rose(st_q.pend) |-> !$past(prog_eff)) // R10 R11
        else $error("boundary break pended in program-only mode");

    chk_swi_exec: assert property (cpu_tag_exec_in && !bdm_active_in // R3 R20
                                   && (mode == HBC_MODE_SWI_DUAL) |=> swi_req_out)
        else $error("tagged execution gave no software interrupt");

endmodule

// >>> src/hbc_pkg.sv
// Purpose: shared constants and types for the hardware breakpoint compare unit
// Assumes: 32-bit memory-mapped bus, one register per aligned word
// Notes:   register indices are scaled by four to form byte addresses
package hbc_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] HBC_IDX_CTRL0   = 6'h20;
    localparam logic [5:0] HBC_IDX_CTRL1   = 6'h21;
    localparam logic [5:0] HBC_IDX_ADDR_HI = 6'h22;
    localparam logic [5:0] HBC_IDX_ADDR_LO = 6'h23;
    localparam logic [5:0] HBC_IDX_DATA_HI = 6'h24;
    localparam logic [5:0] HBC_IDX_DATA_LO = 6'h25;
    localparam logic [5:0] HBC_IDX_STATUS  = 6'h26;

    // break_control_0 field positions
    localparam int HBC_C0_MODE_HI   = 7;
    localparam int HBC_C0_MODE_LO   = 6;
    localparam int HBC_C0_PROG_ONLY = 5;
    localparam int HBC_C0_SIZE_SEL  = 2;
    localparam int HBC_C0_RANGE2    = 1;
    localparam int HBC_C0_RANGE1    = 0;

    // break_control_1 field positions
    localparam int HBC_C1_DATA_EN   = 6;
    localparam int HBC_C1_HI_MASK   = 5;
    localparam int HBC_C1_LO_MASK   = 4;
    localparam int HBC_C1_DIR2_EN   = 3;
    localparam int HBC_C1_DIR2_VAL  = 2;
    localparam int HBC_C1_DIR1_EN   = 1;
    localparam int HBC_C1_DIR1_VAL  = 0;

    // status field positions
    localparam int HBC_ST_HIT1      = 0;
    localparam int HBC_ST_HIT2      = 1;
    localparam int HBC_ST_PEND      = 2;

    // reset values, control 1 write mask and zero read word
    localparam logic [7:0]  HBC_RST_BYTE  = 8'h00;
    localparam logic [7:0]  HBC_C1_WMASK  = 8'h7f;
    localparam logic [31:0] HBC_RD_ZERO   = 32'h0000_0000;

    // breakpoint mode select encodings
    typedef enum logic [1:0]
    {
        HBC_MODE_OFF      = 2'b00,
        HBC_MODE_SWI_DUAL = 2'b01,
        HBC_MODE_DBG_FULL = 2'b10,
        HBC_MODE_DBG_DUAL = 2'b11
    } hbc_mode_t;

endpackage

// >>> test/hbc_cpu_model.sv
// Purpose: behavioural cpu bus partner for the breakpoint compare unit
// Assumes: one bus cycle per call, then an instruction boundary two cycles later
// Notes:   released address and data lines show the inverse of the last value
module hbc_cpu_model
(
    input  wire logic        clk_in,
    input  wire logic        tag_in,
    output logic      [15:0] cpu_addr_out,
    output logic      [15:0] cpu_data_out,
    output logic             cpu_read_out,
    output logic             cpu_valid_out,
    output logic             cpu_fetch_out,
    output logic             cpu_boundary_out,
    output logic             cpu_tag_exec_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic exec_q;

    // quiet bus before the first cycle
    initial
    begin
        cpu_addr_out     = 16'h0000;
        cpu_data_out     = 16'h0000;
        cpu_read_out     = 1'b1;
        cpu_valid_out    = 1'b0;
        cpu_fetch_out    = 1'b0;
        cpu_boundary_out = 1'b0;
        cpu_tag_exec_out = 1'b0;
        exec_q           = 1'b0;
    end

    // one bus cycle; ex says whether a fetched opcode really executes
    task automatic run(input logic [15:0] a, input logic [15:0] d, input logic rd, input logic f,
                       input logic ex);
        @(posedge clk_in);
        cpu_addr_out  <= a;
        cpu_data_out  <= d;
        cpu_read_out  <= rd;
        cpu_fetch_out <= f;
        cpu_valid_out <= 1'b1;
        exec_q        <= ex;
        @(posedge clk_in);
        cpu_valid_out <= 1'b0;
        cpu_fetch_out <= 1'b0;
        cpu_addr_out  <= ~a; // released bus does not keep the old value
        cpu_data_out  <= ~d;
        @(posedge clk_in);
        cpu_boundary_out <= 1'b1;
        @(posedge clk_in);
        cpu_boundary_out <= 1'b0;
    endtask

    // a tagged opcode reaches execution on the cycle after its tag, unless skipped
    always @(posedge clk_in)
    begin
        cpu_tag_exec_out <= (tag_in === 1'b1) && exec_q;
    end
endmodule

// >>> test/testbench.sv
// Purpose: self-checking bench for the breakpoint compare unit
// Assumes: compare values 0x1234 and 0x5678 loaded before the mode table runs
// Notes:   pulses are counted per scenario and compared against expected counts
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [7:0]  av_addr = 8'h00;
    logic        av_rd = 1'b0;
    logic        av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [3:0]  av_be = 4'h0;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic [15:0] c_addr, c_data;
    logic        c_read, c_valid, c_fetch, c_bound, c_exec;
    logic        bdm_act = 1'b0;
    logic        bdm_en = 1'b0;
    logic        tag, dbg, swi;
    logic [31:0] q;
    int          bad_count = 0;
    int          tests_run = 0;
    int          n_tag = 0, n_dbg = 0, n_swi = 0;

    hbc_breakpoint hbc_breakpoint_i (.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(av_addr),
        .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_byteenable_in(av_be),
        .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait), .cpu_addr_in(c_addr),
        .cpu_data_in(c_data), .cpu_read_in(c_read), .cpu_valid_in(c_valid), .cpu_fetch_in(c_fetch),
        .cpu_boundary_in(c_bound), .cpu_tag_exec_in(c_exec), .bdm_active_in(bdm_act),
        .bdm_enable_in(bdm_en), .tag_out(tag), .dbg_req_out(dbg), .swi_req_out(swi));

    hbc_cpu_model hbc_cpu_model_i (.clk_in(clk_in), .tag_in(tag), .cpu_addr_out(c_addr),
        .cpu_data_out(c_data), .cpu_read_out(c_read), .cpu_valid_out(c_valid), .cpu_fetch_out(c_fetch),
        .cpu_boundary_out(c_bound), .cpu_tag_exec_out(c_exec));

    // 10 MHz clock
    initial
    begin
        forever #50 clk_in = ~clk_in;
    end

    // count one-cycle request pulses
    always @(posedge clk_in)
    begin
        n_tag += (tag === 1'b1);
        n_dbg += (dbg === 1'b1);
        n_swi += (swi === 1'b1);
    end

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic check_cnt(input string nm, input int exp, input int got);
        tests_run++;
        if (got != exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // one register access held until waitrequest is sampled low
    task automatic av_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk_in);
        av_addr  <= a;
        av_wdata <= {24'h000000, d};
        av_be    <= be;
        av_wr    <= wr;
        av_rd    <= !wr;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (av_wait !== 1'b0 && n < 20);
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        if (av_wait !== 1'b0)
        begin
            bad_count++;
            test_done();
        end
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        av_xfer(1'b0, a, 8'h00, 4'hf);
        check_reg(nm, exp, q);
    endtask

    // fl = {read, fetch, executes, bdm active, bdm enable}; ex = {tag, dbg, swi}
    task automatic scen(input logic [7:0] c0, input logic [7:0] c1, input logic [15:0] a,
                        input logic [15:0] d, input logic [4:0] fl, input logic [2:0] ex);
        int t0, d0, s0;
        bdm_act <= fl[1];
        bdm_en  <= fl[0];
        av_xfer(1'b1, 8'h80, c0, 4'hf);
        av_xfer(1'b1, 8'h84, c1, 4'hf);
        t0 = n_tag;
        d0 = n_dbg;
        s0 = n_swi;
        hbc_cpu_model_i.run(a, d, fl[4], fl[3], fl[2]);
        repeat (3) @(posedge clk_in);
        check_cnt("tag", int'(ex[2]), n_tag - t0);
        check_cnt("dbg", int'(ex[1]), n_dbg - d0);
        check_cnt("swi", int'(ex[0]), n_swi - s0);
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        reg_rd(8'h84, 32'h0, "ctrl1 reset");
        av_xfer(1'b1, 8'h84, 8'hff, 4'hf);
        reg_rd(8'h84, 32'h7f, "ctrl1 top bit");
        av_xfer(1'b1, 8'h84, 8'h01, 4'h0);
        reg_rd(8'h84, 32'h7f, "ctrl1 lane off");
        av_xfer(1'b1, 8'hfc, 8'h55, 4'hf);
        reg_rd(8'hfc, 32'h0, "unmapped");
        av_xfer(1'b1, 8'h88, 8'h12, 4'hf);
        av_xfer(1'b1, 8'h8c, 8'h34, 4'hf);
        av_xfer(1'b1, 8'h90, 8'h56, 4'hf);
        av_xfer(1'b1, 8'h94, 8'h78, 4'hf);
        reg_rd(8'h8c, 32'h34, "addr low");
        scen(8'h00, 8'h00, 16'h1234, 16'h0000, 5'h1d, 3'h0);
        scen(8'h41, 8'h00, 16'h1234, 16'h0000, 5'h1d, 3'h5);
        scen(8'h41, 8'h00, 16'h1234, 16'h0000, 5'h15, 3'h0);
        scen(8'h41, 8'h02, 16'h1234, 16'h0000, 5'h1d, 3'h5);
        scen(8'h41, 8'h00, 16'h1234, 16'h0000, 5'h19, 3'h4);
        scen(8'h81, 8'h00, 16'h1234, 16'h0000, 5'h15, 3'h2);
        scen(8'h81, 8'h00, 16'h1234, 16'h0000, 5'h14, 3'h0);
        scen(8'h81, 8'h00, 16'h1234, 16'h0000, 5'h17, 3'h0);
        scen(8'h80, 8'h00, 16'h12ff, 16'h0000, 5'h15, 3'h2);
        scen(8'h81, 8'h00, 16'h12ff, 16'h0000, 5'h15, 3'h0);
        scen(8'ha1, 8'h00, 16'h1234, 16'h0000, 5'h15, 3'h0);
        scen(8'ha1, 8'h00, 16'h1234, 16'h0000, 5'h1d, 3'h6);
        scen(8'h81, 8'h40, 16'h1234, 16'h5600, 5'h15, 3'h0);
        scen(8'h81, 8'h50, 16'h1234, 16'h5600, 5'h15, 3'h2);
        scen(8'h81, 8'h60, 16'h1234, 16'h0078, 5'h15, 3'h2);
        scen(8'hc0, 8'h40, 16'h56ab, 16'h0000, 5'h15, 3'h2);
        scen(8'hc2, 8'h40, 16'h56ab, 16'h0000, 5'h15, 3'h0);
        scen(8'hc2, 8'h40, 16'h5678, 16'h0000, 5'h15, 3'h2);
        scen(8'hc2, 8'h00, 16'h5678, 16'h0000, 5'h15, 3'h0);
        scen(8'hc6, 8'h40, 16'h5678, 16'h0000, 5'h15, 3'h2);
        scen(8'hc1, 8'h03, 16'h1234, 16'h0000, 5'h05, 3'h0);
        scen(8'hc1, 8'h03, 16'h1234, 16'h0000, 5'h15, 3'h2);
        scen(8'hc1, 8'h02, 16'h1234, 16'h0000, 5'h05, 3'h2);
        scen(8'hc2, 8'h4c, 16'h5678, 16'h0000, 5'h05, 3'h0);
        scen(8'h42, 8'h40, 16'h5678, 16'h0000, 5'h1d, 3'h5);
        scen(8'h85, 8'h40, 16'h1234, 16'h0078, 5'h15, 3'h2);
        scen(8'he1, 8'h40, 16'h1234, 16'h0000, 5'h15, 3'h0);
        scen(8'he1, 8'h40, 16'h1234, 16'h0000, 5'h1d, 3'h6);
        // sticky hit flags, then write one to clear
        reg_rd(8'h98, 32'h3, "status hits");
        reg_rd(8'h80, 32'he1, "ctrl0 readback");
        av_xfer(1'b1, 8'h98, 8'h03, 4'hf);
        reg_rd(8'h98, 32'h0, "status clear");
        // second reset in mid-run must bring the controls back to zero
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        reg_rd(8'h84, 32'h0, "ctrl1 after reset");
        reg_rd(8'h80, 32'h0, "ctrl0 after reset");
        test_done();
    end
endmodule
